// File: eecc_cfg.svh
// Constants of the data-store command controller: offsets, fields, command codes, counts
`ifndef EECC_CFG_SVH
`define EECC_CFG_SVH

`define EECC_ROWS_N 1024
`define EECC_ROWS 11'h400
`define EECC_UNIT_ROWS 11'h020
`define EECC_PROT_ADDR 11'h7fd

`define EECC_REG_CLKDIV 4'h0
`define EECC_REG_TEST_A 4'h1
`define EECC_REG_TEST_B 4'h2
`define EECC_REG_CNFG 4'h3
`define EECC_REG_PROT 4'h4
`define EECC_REG_STAT 4'h5
`define EECC_REG_CMD 4'h6
`define EECC_REG_TEST_C 4'h7
`define EECC_REG_ADDR_HI 4'h8
`define EECC_REG_ADDR_LO 4'h9
`define EECC_REG_DATA_HI 4'ha
`define EECC_REG_DATA_LO 4'hb

`define EECC_DIVLD 7
`define EECC_PRESCALE8 6
`define EECC_BUF_EMPTY_IE 7
`define EECC_CMD_DONE_IE 6
`define EECC_OPEN 7
`define EECC_EPDIS 3
`define EECC_BUF_EMPTY 7
`define EECC_CMD_DONE 6
`define EECC_PROT_VIOL 5
`define EECC_ACCERR 4
`define EECC_BLANK 2
`define EECC_CMD_MASK 8'h65

`define EECC_CMD_VERIFY 8'h05
`define EECC_CMD_PROG 8'h20
`define EECC_CMD_SERASE 8'h40
`define EECC_CMD_MERASE 8'h41

`define EECC_INVALID_RD 16'h0000
`define EECC_PROG_TICKS 16'h0006
`define EECC_SERASE_TICKS 16'h0028
`define EECC_MERASE_TICKS 16'h0190
`define EECC_VERIFY_TICKS 16'h0002

`endif

// File: eecc_pkg.sv
// Types shared by the data-store command controller and its array
`default_nettype none
`include "eecc_cfg.svh"
package eecc_pkg;
    typedef enum logic [1:0] {EX_LOAD, EX_IDLE, EX_RUN} eecc_ex_t;
    typedef enum logic [1:0] {SQ_IDLE, SQ_ADDR, SQ_CMD} eecc_seq_t;
    typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_SERASE, OP_MERASE} eecc_op_t;

    typedef struct packed {
        logic [`EECC_ROWS_N-1:0][15:0] mem;
    } eecc_arr_st_t;

    typedef struct packed {
        eecc_ex_t ex;
        eecc_seq_t seq;
        logic [7:0] clkdiv;
        logic be;
        logic cc;
        logic [7:0] prot;
        logic buf_empty;
        logic cmd_done;
        logic prot_viol;
        logic accerr;
        logic blank;
        logic buf_full;
        logic [7:0] buf_cmd;
        logic [9:0] buf_row;
        logic [15:0] buf_data;
        logic [7:0] run_cmd;
        logic [9:0] run_row;
        logic [15:0] run_data;
        logic [15:0] timer;
        logic [8:0] cnt;
        logic rd_mis;
        logic [15:0] rdata;
        logic ack;
        logic ready;
        logic irq;
    } eecc_top_st_t;
endpackage : eecc_pkg
`default_nettype wire

// File: eecc_arr_if.sv
// Carrier between the controller and its storage array
`timescale 1ns/10ps
`default_nettype none
interface eecc_arr_if;
    eecc_pkg::eecc_op_t op;
    logic [9:0] op_row;
    logic [15:0] op_data;
    logic [9:0] rd_row_a;
    logic [9:0] rd_row_b;
    logic [15:0] rd_a;
    logic [15:0] rd_b;
    logic blank;
    modport ctrl(output op, op_row, op_data, rd_row_a, rd_row_b, input rd_a, rd_b, blank);
    modport mem(input op, op_row, op_data, rd_row_a, rd_row_b, output rd_a, rd_b, blank);
endinterface : eecc_arr_if
`default_nettype wire

// File: eecc_array.sv
// Storage array of the data store, held in flip-flops
`timescale 1ns/10ps
`default_nettype none
module eecc_array (
    input wire logic clk,
    input wire logic rstn,
    eecc_arr_if.mem a
);
    import eecc_pkg::*;

    eecc_arr_st_t st;
    eecc_arr_st_t next_st;

    // ----------------------------------------
    // Program and erase
    // ----------------------------------------
    always_comb begin
        next_st = st;
        case (a.op)
            // Programming can only pull bits to zero
            OP_PROG: next_st.mem[a.op_row] = st.mem[a.op_row] & a.op_data;
            OP_SERASE: begin
                next_st.mem[{a.op_row[9:1], 1'b0}] = 16'hffff;
                next_st.mem[{a.op_row[9:1], 1'b1}] = 16'hffff;
            end
            OP_MERASE: next_st.mem = '1;
            default: begin
            end
        endcase
    end

    assign a.rd_a = st.mem[a.rd_row_a];
    assign a.rd_b = st.mem[a.rd_row_b];
    assign a.blank = &st.mem;

    // Stand-in for nonvolatile cells: reset shows an erased array
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end
endmodule : eecc_array
`default_nettype wire

// File: eecc_top.sv
// Command controller of the emulated word-programmable data store
`timescale 1ns/10ps
`default_nettype none
`include "eecc_cfg.svh"
module eecc_top #(
    parameter logic [15:0] PROG_TICKS = `EECC_PROG_TICKS,
    parameter logic [15:0] SERASE_TICKS = `EECC_SERASE_TICKS,
    parameter logic [15:0] MERASE_TICKS = `EECC_MERASE_TICKS,
    parameter logic [15:0] VERIFY_TICKS = `EECC_VERIFY_TICKS
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic REQ,
    input wire logic WE,
    input wire logic REG_SEL,
    input wire logic WORD,
    input wire logic [10:0] ADDR,
    input wire logic [15:0] WDATA,
    output wire logic [15:0] RDATA,
    output wire logic ACK,
    output wire logic READY,
    output wire logic IRQ
);
    import eecc_pkg::*;

    eecc_top_st_t st;
    eecc_top_st_t next_st;
    eecc_arr_if arr ();
    logic tick;
    logic take;
    logic seq_bad;
    logic [3:0] ra;
    logic [7:0] reg_rd;
    logic [7:0] cmd_w;

    eecc_array u_array (
        .clk(CLK),
        .rstn(RSTN),
        .a(arr)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Wraps at 512, which is exactly the largest legal ratio
    function automatic logic [8:0] ratio_m1(input logic [7:0] cd);
        logic [8:0] base;
        base = {3'h0, cd[5:0]} + 9'h001;
        if (cd[`EECC_PRESCALE8]) begin
            ratio_m1 = {base[5:0], 3'h0} - 9'h001;
        end else begin
            ratio_m1 = base - 9'h001;
        end
    endfunction : ratio_m1

    function automatic logic any_prot(input logic [7:0] p);
        any_prot = !p[`EECC_OPEN] || !p[`EECC_EPDIS];
    endfunction : any_prot

    // Sector size is 64 bytes per step of the size field
    function automatic logic prot_hit(input logic [7:0] p, input logic [9:0] row);
        logic [3:0] ep1;
        logic [10:0] lim;
        ep1 = {1'b0, p[2:0]} + 4'h1;
        lim = `EECC_ROWS - 11'(ep1 * `EECC_UNIT_ROWS);
        prot_hit = !p[`EECC_OPEN] || (!p[`EECC_EPDIS] && ({1'b0, row} >= lim));
    endfunction : prot_hit

    function automatic logic cmd_ok(input logic [7:0] c);
        cmd_ok = (c == `EECC_CMD_PROG) || (c == `EECC_CMD_SERASE)
            || (c == `EECC_CMD_MERASE) || (c == `EECC_CMD_VERIFY);
    endfunction : cmd_ok

    function automatic eecc_op_t op_of(input logic [7:0] c);
        case (c)
            `EECC_CMD_PROG: op_of = OP_PROG;
            `EECC_CMD_SERASE: op_of = OP_SERASE;
            `EECC_CMD_MERASE: op_of = OP_MERASE;
            default: op_of = OP_NONE;
        endcase
    endfunction : op_of

    function automatic logic [15:0] dur(input logic [7:0] c);
        case (c)
            `EECC_CMD_PROG: dur = PROG_TICKS;
            `EECC_CMD_SERASE: dur = SERASE_TICKS;
            `EECC_CMD_MERASE: dur = MERASE_TICKS;
            default: dur = VERIFY_TICKS;
        endcase
    endfunction : dur

    // Big-endian: the even byte is the high half of a row
    function automatic logic [7:0] byte_of(input logic [15:0] w, input logic odd);
        byte_of = odd ? w[7:0] : w[15:8];
    endfunction : byte_of

    // ----------------------------------------
    // Register read decode
    // ----------------------------------------
    always_comb begin
        ra = ADDR[3:0];
        case (ra)
            `EECC_REG_CLKDIV: reg_rd = st.clkdiv;
            `EECC_REG_CNFG: reg_rd = {st.be, st.cc, 6'h00};
            `EECC_REG_PROT: reg_rd = st.prot;
            `EECC_REG_STAT: reg_rd = {st.buf_empty, st.cmd_done, st.prot_viol, st.accerr,
                                      1'b0, st.blank, 2'h0};
            `EECC_REG_CMD: reg_rd = st.buf_cmd;
            `EECC_REG_ADDR_HI: reg_rd = {6'h00, st.buf_row[9:8]};
            `EECC_REG_ADDR_LO: reg_rd = st.buf_row[7:0];
            `EECC_REG_DATA_HI: reg_rd = st.buf_data[15:8];
            `EECC_REG_DATA_LO: reg_rd = st.buf_data[7:0];
            // Factory test registers and holes read zero
            default: reg_rd = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        tick = 1'b0;
        take = REQ && st.ready;
        seq_bad = 1'b0;
        cmd_w = WDATA[7:0] & `EECC_CMD_MASK;
        arr.op = OP_NONE;
        arr.op_row = st.run_row;
        arr.op_data = st.run_data;
        arr.rd_row_a = ADDR[10:1];
        arr.rd_row_b = ADDR[10:1] + 10'h001;

        // Timing tick; nothing runs until the divider is loaded
        if (st.clkdiv[`EECC_DIVLD]) begin
            if (st.cnt == ratio_m1(st.clkdiv)) begin
                next_st.cnt = 9'h000;
                tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 9'h001;
            end
        end

        // Execution pipeline: one running command and one buffered
        case (st.ex)
            EX_LOAD: begin
                arr.rd_row_a = 10'(`EECC_PROT_ADDR >> 1);
                next_st.prot = byte_of(arr.rd_a, 1'(`EECC_PROT_ADDR & 11'h001));
                next_st.ex = EX_IDLE;
                next_st.ready = 1'b1;
            end
            EX_IDLE: begin
                if (st.buf_full) begin
                    next_st.run_cmd = st.buf_cmd;
                    next_st.run_row = st.buf_row;
                    next_st.run_data = st.buf_data;
                    next_st.timer = dur(st.buf_cmd);
                    next_st.buf_full = 1'b0;
                    next_st.buf_empty = 1'b1;
                    next_st.ex = EX_RUN;
                    if (st.buf_cmd == `EECC_CMD_VERIFY) begin
                        next_st.blank = 1'b0;
                    end
                end
            end
            EX_RUN: begin
                if (st.timer == 16'h0000) begin
                    arr.op = op_of(st.run_cmd);
                    if (st.run_cmd == `EECC_CMD_VERIFY) begin
                        next_st.blank = arr.blank;
                    end
                    next_st.ex = EX_IDLE;
                    if (!st.buf_full) begin
                        next_st.cmd_done = 1'b1;
                    end
                end else if (tick) begin
                    next_st.timer = st.timer - 16'h0001;
                end
            end
            default: next_st.ex = EX_IDLE;
        endcase

        // Second half of a misaligned read
        if (st.rd_mis) begin
            next_st.rd_mis = 1'b0;
            next_st.ack = 1'b1;
            next_st.ready = 1'b1;
        end

        // ----------------------------------------
        // Bus access
        // ----------------------------------------
        if (take && !WE) begin
            next_st.ack = 1'b1;
            if (REG_SEL) begin
                next_st.rdata = {8'h00, reg_rd};
            end else if (!st.cmd_done) begin
                next_st.rdata = `EECC_INVALID_RD;
            end else if (!WORD) begin
                next_st.rdata = {8'h00, byte_of(arr.rd_a, ADDR[0])};
            end else if (!ADDR[0]) begin
                next_st.rdata = arr.rd_a;
            end else begin
                // Straddles two rows, so one wait cycle is inserted
                next_st.rdata = {arr.rd_a[7:0], arr.rd_b[15:8]};
                next_st.ack = 1'b0;
                next_st.ready = 1'b0;
                next_st.rd_mis = 1'b1;
            end
        end

        if (take && WE && REG_SEL) begin
            next_st.ack = 1'b1;
            // Error flags clear on a one; a same-cycle set below still wins
            if (ra == `EECC_REG_STAT) begin
                if (WDATA[`EECC_PROT_VIOL]) begin
                    next_st.prot_viol = 1'b0;
                end
                if (WDATA[`EECC_ACCERR]) begin
                    next_st.accerr = 1'b0;
                end
            end
            seq_bad = ((st.seq == SQ_ADDR) && (ra != `EECC_REG_CMD))
                || ((st.seq == SQ_CMD) && (ra != `EECC_REG_STAT));
            if (seq_bad) begin
                next_st.accerr = 1'b1;
                next_st.seq = SQ_IDLE;
            end else begin
                case (ra)
                    `EECC_REG_CLKDIV: begin
                        if (!st.clkdiv[`EECC_DIVLD]) begin
                            next_st.clkdiv = {1'b1, WDATA[6:0]};
                        end
                    end
                    `EECC_REG_CNFG: begin
                        next_st.be = WDATA[`EECC_BUF_EMPTY_IE];
                        next_st.cc = WDATA[`EECC_CMD_DONE_IE];
                    end
                    `EECC_REG_PROT: begin
                        // Open and disable bits can only move toward protected
                        next_st.prot[`EECC_OPEN] = st.prot[`EECC_OPEN]
                            & WDATA[`EECC_OPEN];
                        next_st.prot[`EECC_EPDIS] = st.prot[`EECC_EPDIS] & WDATA[`EECC_EPDIS];
                        if (st.prot[`EECC_EPDIS]) begin
                            next_st.prot[2:0] = WDATA[2:0];
                        end
                    end
                    `EECC_REG_STAT: begin
                        if (st.seq == SQ_CMD) begin
                            next_st.seq = SQ_IDLE;
                            if (WDATA[`EECC_BUF_EMPTY]) begin
                                next_st.buf_full = 1'b1;
                                next_st.buf_empty = 1'b0;
                                next_st.cmd_done = 1'b0;
                            end else begin
                                next_st.accerr = 1'b1;
                            end
                        end
                    end
                    `EECC_REG_CMD: begin
                        next_st.seq = SQ_IDLE;
                        if (st.seq != SQ_ADDR) begin
                            next_st.accerr = 1'b1;
                        end else if (!cmd_ok(cmd_w)) begin
                            next_st.accerr = 1'b1;
                        end else if (((cmd_w == `EECC_CMD_PROG) || (cmd_w == `EECC_CMD_SERASE))
                                     && prot_hit(st.prot, st.buf_row)) begin
                            next_st.prot_viol = 1'b1;
                        end else if ((cmd_w == `EECC_CMD_MERASE) && any_prot(st.prot)) begin
                            next_st.prot_viol = 1'b1;
                        end else begin
                            next_st.buf_cmd = cmd_w;
                            next_st.seq = SQ_CMD;
                        end
                    end
                    `EECC_REG_ADDR_HI: begin
                        if (!st.buf_full) begin
                            next_st.buf_row[9:8] = WDATA[1:0];
                        end
                    end
                    `EECC_REG_ADDR_LO: begin
                        if (!st.buf_full) begin
                            next_st.buf_row[7:0] = WDATA[7:0];
                        end
                    end
                    `EECC_REG_DATA_HI: begin
                        if (!st.buf_full) begin
                            next_st.buf_data[15:8] = WDATA[7:0];
                        end
                    end
                    `EECC_REG_DATA_LO: begin
                        if (!st.buf_full) begin
                            next_st.buf_data[7:0] = WDATA[7:0];
                        end
                    end
                    // Factory test registers ignore writes
                    default: begin
                    end
                endcase
            end
        end

        // Array write opens a sequence; anything out of place is an access error
        if (take && WE && !REG_SEL) begin
            next_st.ack = 1'b1;
            if (WORD && !ADDR[0] && (st.seq == SQ_IDLE) && st.buf_empty
                && st.clkdiv[`EECC_DIVLD] && !st.prot_viol && !st.accerr) begin
                next_st.buf_row = ADDR[10:1];
                next_st.buf_data = WDATA;
                next_st.seq = SQ_ADDR;
            end else begin
                next_st.accerr = 1'b1;
                next_st.seq = SQ_IDLE;
            end
        end

        // Request follows the new flag values so it moves with them
        next_st.irq = (next_st.buf_empty && next_st.be)
            || (next_st.cmd_done && next_st.cc);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st <= '0;
            st.ex <= EX_LOAD;
            st.seq <= SQ_IDLE;
            st.buf_empty <= 1'b1;
            st.cmd_done <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Only internal bus and one interrupt line leave the block
    assign RDATA = st.rdata;
    assign ACK = st.ack;
    assign READY = st.ready;
    assign IRQ = st.irq;
endmodule : eecc_top
`default_nettype wire

// File: eecc_chk.sv
// Port-level assertions of the data-store command controller
`timescale 1ns/10ps
`default_nettype none
module eecc_chk (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic REQ,
    input wire logic WE,
    input wire logic REG_SEL,
    input wire logic WORD,
    input wire logic [10:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic [15:0] RDATA,
    input wire logic ACK,
    input wire logic READY,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    logic take;
    logic mis;
    logic ro;
    assign take = REQ && READY;
    assign mis = take && !WE && !REG_SEL && WORD && ADDR[0];
    assign ro = ADDR[3:0] == 4'h1 || ADDR[3:0] == 4'h2 || ADDR[3:0] == 4'h7;
    a_ack_next: assert property (take && !mis |=> ACK) else $error("ack late");
    a_mis_wait: assert property (mis |=> !READY && !ACK ##1 READY && ACK)
        else $error("misaligned timing");
    a_ready_short: assert property (!READY |=> READY) else $error("ready low");
    a_no_spur: assert property (ACK |-> $past(take) || !$past(READY))
        else $error("spurious ack");
    a_test_zero: assert property (take && REG_SEL && !WE && ro |=> RDATA == 16'h0000)
        else $error("test register nonzero");
    a_byte_high: assert property (take && !WE && (REG_SEL || !WORD)
        |=> RDATA[15:8] == 8'h00) else $error("byte upper half");
    // A misaligned read loads its data one cycle ahead of its acknowledge
    a_rdata_hold: assert property (!ACK && !$past(mis) |-> $stable(RDATA))
        else $error("rdata moved");
    a_wr_fast: assert property (take && WE |=> READY) else $error("write stall");
    c_mis: cover property (mis ##2 ACK);
    c_irq: cover property ($rose(IRQ));
    c_reg_wr: cover property (take && WE && REG_SEL);
endmodule : eecc_chk
bind eecc_top eecc_chk u_eecc_chk (.CLK(CLK), .RSTN(RSTN), .REQ(REQ), .WE(WE), .REG_SEL(REG_SEL),
    .WORD(WORD), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .ACK(ACK), .READY(READY), .IRQ(IRQ));
`default_nettype wire

// File: eecc_cpu.sv
// Bus-master model of the processor core facing the controller
`timescale 1ns/10ps
`default_nettype none
module eecc_cpu (
    input wire logic clk,
    input wire logic ready,
    input wire logic ack,
    input wire logic [15:0] rdata,
    output var logic req,
    output var logic we,
    output var logic rsel,
    output var logic word,
    output var logic [10:0] addr,
    output var logic [15:0] wdata
);
    initial begin
        req = 1'b0;
        we = 1'b0;
        rsel = 1'b0;
        word = 1'b0;
        addr = 11'h000;
        wdata = 16'h0000;
    end
    // One access; a missing answer comes back as unknown data
    task automatic acc(input logic w, input logic r, input logic wd, input logic [10:0] a,
            input logic [15:0] d, output logic [15:0] q);
        logic got;
        int n;
        @(negedge clk);
        while (ready !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        req = 1'b1;
        we = w;
        rsel = r;
        word = wd;
        addr = a;
        wdata = d;
        @(posedge clk);
        // The answer stands for the whole cycle after the taking edge
        @(negedge clk);
        got = ack;
        q = rdata;
        req = 1'b0;
        // Released lines change so late sampling shows up
        addr = ~addr;
        wdata = ~wdata;
        if (got !== 1'b1) begin
            @(negedge clk);
            got = ack;
            q = rdata;
        end
        if (got !== 1'b1) q = 16'hxxxx;
    endtask : acc
    task automatic cmd(input logic [10:0] a, input logic [15:0] d, input logic [7:0] c);
        logic [15:0] q;
        acc(1'b1, 1'b0, 1'b1, a, d, q);
        acc(1'b1, 1'b1, 1'b0, 11'h006, {8'h00, c}, q);
        acc(1'b1, 1'b1, 1'b0, 11'h005, 16'h0080, q);
    endtask : cmd
endmodule : eecc_cpu
`default_nettype wire

// File: eecc_top_tb.sv
// Self-checking bench of the data-store command controller
`timescale 1ns/10ps
`default_nettype none
module eecc_top_tb;
    import eecc_pkg::*;
    logic CLK, RSTN, REQ, WE, REG_SEL, WORD, ACK, READY, IRQ;
    logic [10:0] ADDR;
    logic [15:0] WDATA, RDATA, q;
    int failures = 0;
    int total_checks = 0;
    logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hc0,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [3:0] ro [3] = '{4'h1, 4'h2, 4'h7};
    eecc_top #(.PROG_TICKS(16'h0008), .SERASE_TICKS(16'h0004), .MERASE_TICKS(16'h0004),
        .VERIFY_TICKS(16'h0002)) u_eecc_top (.CLK(CLK), .RSTN(RSTN), .REQ(REQ), .WE(WE),
        .REG_SEL(REG_SEL), .WORD(WORD), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .ACK(ACK),
        .READY(READY), .IRQ(IRQ));
    eecc_cpu u_eecc_cpu (.clk(CLK), .ready(READY), .ack(ACK), .rdata(RDATA), .req(REQ),
        .we(WE), .rsel(REG_SEL), .word(WORD), .addr(ADDR), .wdata(WDATA));
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rg(input logic [3:0] o, input logic [7:0] e);
        u_eecc_cpu.acc(1'b0, 1'b1, 1'b0, {7'h00, o}, 16'h0000, q);
        chk("register", {8'h00, e}, q);
    endtask : rg
    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        u_eecc_cpu.acc(1'b1, 1'b1, 1'b0, {7'h00, o}, {8'h00, d}, q);
    endtask : wr
    task automatic ar(input logic wd, input logic [10:0] a, input logic [15:0] e);
        u_eecc_cpu.acc(1'b0, 1'b0, wd, a, 16'h0000, q);
        chk("array", e, q);
    endtask : ar
    task automatic irq(input logic e);
        @(negedge CLK);
        chk("irq", {15'h0000, e}, {15'h0000, IRQ});
    endtask : irq
    task automatic waitcc();
        int n;
        do begin
            u_eecc_cpu.acc(1'b0, 1'b1, 1'b0, 11'h005, 16'h0000, q);
            n++;
        end while (q[6] !== 1'b1 && n < 200);
        chk("complete", 16'h0040, q & 16'h0040);
    endtask : waitcc
    // Refused launch: word and command only, then violation flag cleared
    task automatic pv(input logic [10:0] a, input logic [7:0] c);
        u_eecc_cpu.acc(1'b1, 1'b0, 1'b1, a, 16'h0000, q);
        wr(4'h6, c);
        rg(4'h5, 8'he4);
        wr(4'h5, 8'h20);
    endtask : pv
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        RSTN = 1'b0;
        repeat (5) @(posedge CLK);
        @(negedge CLK);
        RSTN = 1'b1;
        for (int i = 0; i < 12; i++) rg(i[3:0], rv[i]);
        u_eecc_cpu.acc(1'b0, 1'b1, 1'b0, 11'h00c, 16'h0000, q);
        chk("unmapped ack", 16'h0000, {15'h0000, q === 16'hxxxx});
        for (int i = 0; i < 3; i++) begin
            wr(ro[i], 8'hff);
            rg(ro[i], 8'h00);
        end
        // Tick every clock keeps the timed algorithms short
        wr(4'h0, 8'h00);
        rg(4'h0, 8'h80);
        wr(4'h0, 8'h45);
        rg(4'h0, 8'h80);
        wr(4'h3, 8'h80);
        rg(4'h3, 8'h80);
        irq(1'b1);
        wr(4'h3, 8'h40);
        ar(1'b0, 11'h010, 16'h00ff);
        ar(1'b1, 11'h010, 16'hffff);
        // Only erased words are programmed
        u_eecc_cpu.cmd(11'h010, 16'h1234, 8'h20);
        irq(1'b0);
        ar(1'b1, 11'h010, 16'h0000);
        waitcc();
        irq(1'b1);
        ar(1'b1, 11'h010, 16'h1234);
        ar(1'b0, 11'h011, 16'h0034);
        ar(1'b1, 11'h011, 16'h34ff);
        u_eecc_cpu.cmd(11'h014, 16'h00ff, 8'h20);
        waitcc();
        u_eecc_cpu.cmd(11'h010, 16'h0000, 8'h40);
        waitcc();
        ar(1'b1, 11'h010, 16'hffff);
        ar(1'b1, 11'h014, 16'h00ff);
        u_eecc_cpu.cmd(11'h000, 16'hffff, 8'h41);
        waitcc();
        ar(1'b1, 11'h014, 16'hffff);
        u_eecc_cpu.cmd(11'h000, 16'hffff, 8'h05);
        waitcc();
        rg(4'h5, 8'hc4);
        wr(4'h6, 8'h20);
        rg(4'h5, 8'hd4);
        wr(4'h5, 8'h10);
        rg(4'h5, 8'hc4);
        wr(4'h4, 8'hf0);
        rg(4'h4, 8'hf0);
        pv(11'h7c0, 8'h20);
        u_eecc_cpu.cmd(11'h7be, 16'h5a5a, 8'h20);
        waitcc();
        ar(1'b1, 11'h7be, 16'h5a5a);
        pv(11'h000, 8'h41);
        wr(4'h4, 8'h70);
        wr(4'h4, 8'hff);
        rg(4'h4, 8'h70);
        pv(11'h000, 8'h20);
        test_done();
    end
    initial begin
        #400000;
        failures++;
        test_done();
    end
endmodule : eecc_top_tb
`default_nettype wire
